/* src/plfc_defs.svh */
// Constants for the per-port learning and flooding control block
`ifndef PLFC_DEFS_SVH
`define PLFC_DEFS_SVH
`define PLFC_MODE_W 3
`define PLFC_MODE_STANDARD 3'h1
`define PLFC_MODE_WORKGROUP 3'h2
`define PLFC_MODE_BACKBONE 3'h3
`define PLFC_MODE_MANUAL 3'h4
`define PLFC_NUM_PORTS 14
`define PLFC_NUM_LOW_PORTS 12
`endif

/* src/plfc_pkg.sv */
// Types for the per-port learning and flooding control block
`include "plfc_defs.svh"
package plfc_pkg;
    // One frame decision request
    typedef struct packed {
        logic [3:0] src_port;
        logic known;
        logic [15:0] static_mask;
        logic [15:0] auth_mask;
        logic [15:0] fwd_mask;
    } plfc_req_t;
    // One frame decision answer
    typedef struct packed {
        logic learn;
        logic [15:0] dest_mask;
    } plfc_res_t;
endpackage

/* src/plfc_port_policy.sv */
// Per-port mode decode into learn and flood permissions
`timescale 1ns/1ps
`include "plfc_defs.svh"
module plfc_port_policy
    import plfc_pkg::*;
(
    input wire logic [`PLFC_MODE_W-1:0] mode_i,
    output logic learn_o,
    output logic flood_o,
    output logic manual_o
);
    // Unknown codes fall back to no learning and no flooding, the safe side
    always_comb
    begin
        learn_o = 1'b0;
        flood_o = 1'b0;
        manual_o = 1'b0;
        case (mode_i)
            `PLFC_MODE_STANDARD:
            begin
                learn_o = 1'b1;
                flood_o = 1'b1;
            end
            `PLFC_MODE_WORKGROUP:
            begin
                learn_o = 1'b1;
                flood_o = 1'b0;
            end
            `PLFC_MODE_BACKBONE:
            begin
                learn_o = 1'b0;
                flood_o = 1'b1;
            end
            `PLFC_MODE_MANUAL:
            begin
                manual_o = 1'b1;
            end
            default:
            begin
                learn_o = 1'b0;
            end
        endcase
    end
endmodule

/* src/plfc_top.sv */
// Learning and flooding control for all ports of a multiport bridge
`timescale 1ns/1ps
`include "plfc_defs.svh"
module plfc_top
    import plfc_pkg::*;
#(
    parameter int NUM_PORTS = `PLFC_NUM_PORTS,
    parameter int NUM_LOW_PORTS = `PLFC_NUM_LOW_PORTS
)
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic mode_we_i,
    input wire logic [3:0] mode_port_i,
    input wire logic [`PLFC_MODE_W-1:0] mode_val_i,
    input wire logic [3:0] mode_rd_port_i,
    output logic [`PLFC_MODE_W-1:0] mode_rd_o,
    input wire logic req_valid_i,
    input wire plfc_req_t req_i,
    output logic res_valid_o,
    output plfc_res_t res_o
);
    localparam int PW = 16;

    // Elaboration check: masks are 16 bits, port index is 4 bits
    if (NUM_PORTS < 1 || NUM_PORTS > PW || NUM_LOW_PORTS > NUM_PORTS)
    begin : g_bad
        $error("plfc_top: port count out of range");
    end

    typedef struct packed {
        logic [PW-1:0][`PLFC_MODE_W-1:0] mode;
        logic vld;
        plfc_res_t res;
        logic [`PLFC_MODE_W-1:0] rd;
    } plfc_state_t;

    plfc_state_t s_q;
    plfc_state_t s_d;
    logic [PW-1:0] learn_ok;
    logic [PW-1:0] flood_ok;
    logic [PW-1:0] manual;

    // One decoder per port, so each port decides from its own mode only
    for (genvar p = 0; p < PW; p++)
    begin : g_port
        plfc_port_policy u_pol (
            .mode_i(s_q.mode[p]),
            .learn_o(learn_ok[p]),
            .flood_o(flood_ok[p]),
            .manual_o(manual[p])
        );
    end

    // Next state: mode writes and one-cycle-latency frame decisions
    always_comb
    begin
        logic [PW-1:0] dest;
        logic [PW-1:0] valid_ports;
        logic [PW-1:0] src_bit;
        s_d = s_q;
        dest = '0;
        valid_ports = PW'((32'h1 << NUM_PORTS) - 1);
        src_bit = PW'(16'h1) << req_i.src_port;
        s_d.rd = s_q.mode[mode_rd_port_i];
        // Decision uses the registered modes, so a write is seen next cycle on
        if (req_valid_i)
        begin
            for (int p = 0; p < PW; p++)
            begin
                if (manual[p])
                begin
                    // Only static filters or security authorizations reach it
                    dest[p] = req_i.static_mask[p] | req_i.auth_mask[p];
                end
                else if (req_i.known)
                begin
                    dest[p] = req_i.fwd_mask[p];
                end
                else
                begin
                    dest[p] = flood_ok[p];
                end
            end
            s_d.res.dest_mask = dest & valid_ports & ~src_bit;
            s_d.res.learn = learn_ok[req_i.src_port];
        end
        s_d.vld = req_valid_i;
        // Out-of-range ports and codes are ignored to keep modes legal
        if (mode_we_i && (32'(mode_port_i) < NUM_PORTS) && mode_val_i >= `PLFC_MODE_STANDARD
            && mode_val_i <= `PLFC_MODE_MANUAL)
        begin
            s_d.mode[mode_port_i] = mode_val_i;
        end
    end

    // State register; reset wins, otherwise clock enable low freezes everything
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
            for (int p = 0; p < PW; p++)
            begin
                s_q.mode[p] <= (p < NUM_LOW_PORTS) ? `PLFC_MODE_WORKGROUP
                                                   : `PLFC_MODE_BACKBONE;
            end
        end
        else if (ce_i)
        begin
            s_q <= s_d;
        end
    end

    assign mode_rd_o = s_q.rd;
    assign res_valid_o = s_q.vld;
    assign res_o = s_q.res;

    chk_wg_no_flood: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && req_valid_i && !req_i.known && s_q.mode[0] == `PLFC_MODE_WORKGROUP)
        |=> !res_o.dest_mask[0]) else $error("workgroup port flooded");
    chk_bb_no_learn: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && req_valid_i && s_q.mode[req_i.src_port] == `PLFC_MODE_BACKBONE)
        |=> !res_o.learn) else $error("backbone port learned");
    chk_bb_flood: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && req_valid_i && !req_i.known && req_i.src_port != 4'hD
         && s_q.mode[13] == `PLFC_MODE_BACKBONE)
        |=> res_o.dest_mask[13]) else $error("backbone port not flooded");
    chk_man_static: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && req_valid_i && req_i.src_port != 4'h0 && s_q.mode[0] == `PLFC_MODE_MANUAL)
        |=> res_o.dest_mask[0] == $past(req_i.static_mask[0] | req_i.auth_mask[0]))
        else $error("manual port forwarding wrong");
    chk_man_auth_only: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && req_valid_i && req_i.static_mask == '0 && req_i.auth_mask == '0
         && s_q.mode[2] == `PLFC_MODE_MANUAL) |=> !res_o.dest_mask[2])
        else $error("manual port got unauthorized frame");
    chk_man_no_learn: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && req_valid_i && s_q.mode[req_i.src_port] == `PLFC_MODE_MANUAL)
        |=> !res_o.learn) else $error("manual port learned");
    chk_learn_on: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && req_valid_i && (s_q.mode[req_i.src_port] == `PLFC_MODE_STANDARD
         || s_q.mode[req_i.src_port] == `PLFC_MODE_WORKGROUP))
        |=> res_o.learn) else $error("learning port did not learn");
    chk_mode_write: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && mode_we_i && mode_port_i == 4'h2 && mode_val_i == `PLFC_MODE_MANUAL)
        |=> s_q.mode[2] == `PLFC_MODE_MANUAL) else $error("mode write lost");
    chk_reset_modes: assert property (@(posedge mclk_i)
        $past(rst_i) |-> (s_q.mode[0] == `PLFC_MODE_WORKGROUP
         && s_q.mode[13] == `PLFC_MODE_BACKBONE)) else $error("reset modes wrong");

    // The checks below watch the handshake, the port limits, readback and freeze, plus three single-mode rules.
    // They are kept cheap: each samples one port or one field (chk_ce_freeze takes all of s_q), never a whole loop,
    // so a broken decoder for a single port shows up only if that port is one of the ports used here.

    // Every taken request is answered exactly one enabled cycle later
    chk_res_valid: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && req_valid_i) |=> res_valid_o)
        else $error("request not answered");

    // No answer appears without a request behind it
    chk_idle_valid: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && !req_valid_i) |=> !res_valid_o)
        else $error("answer without request");

    // A frame is never sent back onto the port it came from
    chk_no_self: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && req_valid_i) |=> !res_o.dest_mask[$past(req_i.src_port)])
        else $error("frame reflected to source port");

    // Mask bits above the fitted ports stay clear
    chk_dest_range: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && req_valid_i) |=> (res_o.dest_mask >> NUM_PORTS) == '0)
        else $error("frame sent to missing port");

    // A standard port takes floods from the other ports
    chk_std_flood: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && req_valid_i && !req_i.known && req_i.src_port != 4'h1
         && s_q.mode[1] == `PLFC_MODE_STANDARD)
        |=> res_o.dest_mask[1]) else $error("standard port not flooded");

    // A manual port with no static entry and no authorization gets no flood
    chk_man_no_flood: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && req_valid_i && !req_i.known && !req_i.static_mask[2]
         && !req_i.auth_mask[2] && s_q.mode[2] == `PLFC_MODE_MANUAL)
        |=> !res_o.dest_mask[2]) else $error("manual port flooded");

    // A manual port ignores the learned forwarding mask
    chk_man_no_fwd: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && req_valid_i && req_i.known && !req_i.static_mask[2]
         && !req_i.auth_mask[2] && s_q.mode[2] == `PLFC_MODE_MANUAL)
        |=> !res_o.dest_mask[2]) else $error("manual port took learned path");

    // Readback of a fitted port always shows a legal code
    chk_mode_legal: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && 32'(mode_rd_port_i) < NUM_PORTS)
        |=> (mode_rd_o >= `PLFC_MODE_STANDARD && mode_rd_o <= `PLFC_MODE_MANUAL))
        else $error("illegal mode code held");

    // With the enable low nothing moves, writes included
    chk_ce_freeze: assert property (@(posedge mclk_i) disable iff (rst_i)
        !ce_i |=> $stable(s_q)) else $error("state moved while frozen");
endmodule

/* dv/plfc_station.sv */
// Station-side model that offers one frame decision per call
`timescale 1ns/1ps
module plfc_station
    import plfc_pkg::*;
(
    input wire logic mclk_i,
    output logic req_valid_o,
    output plfc_req_t req_o
);
    // Idle with no frame offered
    initial
    begin
        req_valid_o = 1'b0;
        req_o = '0;
    end

    // One frame per call; fields are scrambled after release so stale data never matches
    task automatic send(input logic [3:0] src, input logic known, input logic [15:0] st,
                        input logic [15:0] au, input logic [15:0] fw);
        @(negedge mclk_i);
        req_valid_o = 1'b1;
        req_o = '{src, known, st, au, fw};
        @(negedge mclk_i);
        req_valid_o = 1'b0;
        req_o = ~req_o;
    endtask
endmodule

/* dv/plfc_top_tb.sv */
// Self-checking bench for the learning and flooding control block
`timescale 1ns/1ps
module plfc_top_tb
    import plfc_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic mode_we_i = 1'b0;
    logic [3:0] mode_port_i = 4'h0;
    logic [2:0] mode_val_i = 3'h0;
    logic [3:0] mode_rd_port_i = 4'h0;
    logic [2:0] mode_rd_o;
    logic req_valid_i;
    plfc_req_t req_i;
    logic res_valid_o;
    plfc_res_t res_o;
    int errors = 0;
    int n_tests = 0;

    // 40 MHz clock
    always #12.5 mclk_i = ~mclk_i;

    plfc_top DUT (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .mode_we_i(mode_we_i),
        .mode_port_i(mode_port_i), .mode_val_i(mode_val_i), .mode_rd_port_i(mode_rd_port_i),
        .mode_rd_o(mode_rd_o), .req_valid_i(req_valid_i), .req_i(req_i),
        .res_valid_o(res_valid_o), .res_o(res_o));

    plfc_station u_sta (.mclk_i(mclk_i), .req_valid_o(req_valid_i), .req_o(req_i));

    // Compare helper; counts every comparison made
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        n_tests++;
        if (s !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    // Mode write as a one-cycle strobe
    task automatic wr(input logic [3:0] p, input logic [2:0] v);
        @(negedge mclk_i);
        mode_we_i = 1'b1;
        mode_port_i = p;
        mode_val_i = v;
        @(negedge mclk_i);
        mode_we_i = 1'b0;
    endtask

    // Write offered while the enable is low; it must not land
    task automatic freeze();
        @(negedge mclk_i);
        ce_i = 1'b0;
        mode_we_i = 1'b1;
        mode_port_i = 4'h4;
        mode_val_i = 3'h1;
        @(negedge mclk_i);
        mode_we_i = 1'b0;
        ce_i = 1'b1;
    endtask

    // Readback answers one cycle after the port index is set
    task automatic rd(input logic [3:0] p, input logic [2:0] e);
        @(negedge mclk_i);
        mode_rd_port_i = p;
        @(negedge mclk_i);
        chk("mode readback", {13'h0000, e}, {13'h0000, mode_rd_o});
    endtask

    // One frame decision; the answer stands in the cycle after the request
    task automatic frame(input logic [3:0] src, input logic known, input logic [15:0] st,
                         input logic [15:0] au, input logic [15:0] fw, input logic el,
                         input logic [15:0] ed);
        u_sta.send(src, known, st, au, fw);
        chk("res valid", 16'h0001, {15'h0000, res_valid_o});
        chk("learn", {15'h0000, el}, {15'h0000, res_o.learn});
        chk("dest mask", ed, res_o.dest_mask);
    endtask

    // Closing task shared by the main sequence and the watchdog
    task automatic end_sim();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog at 4000 cycles, well past the roughly 70 cycles the tests need
    initial
    begin
        #100us;
        errors++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        repeat (20) @(negedge mclk_i);
        rst_i = 1'b0;
        rd(4'h0, 3'h2);
        rd(4'hB, 3'h2);
        rd(4'hC, 3'h3);
        rd(4'hD, 3'h3);
        frame(4'h0, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b1, 16'h3000);
        frame(4'h0, 1'b1, 16'h0000, 16'h0000, 16'h0010, 1'b1, 16'h0010);
        frame(4'hC, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b0, 16'h2000);
        frame(4'hD, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b0, 16'h1000);
        wr(4'h3, 3'h5);
        rd(4'h3, 3'h2);
        wr(4'h1, 3'h1);
        rd(4'h1, 3'h1);
        frame(4'h0, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b1, 16'h3002);
        frame(4'h1, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b1, 16'h3000);
        wr(4'h2, 3'h4);
        rd(4'h2, 3'h4);
        freeze();
        rd(4'h4, 3'h2);
        frame(4'h0, 1'b1, 16'h0000, 16'h0000, 16'h0004, 1'b1, 16'h0000);
        frame(4'h0, 1'b1, 16'h0004, 16'h0000, 16'h0000, 1'b1, 16'h0004);
        frame(4'h0, 1'b0, 16'h0004, 16'h0000, 16'h0000, 1'b1, 16'h3006);
        frame(4'h0, 1'b0, 16'h0000, 16'h0004, 16'h0000, 1'b1, 16'h3006);
        frame(4'h0, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b1, 16'h3002);
        frame(4'h2, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b0, 16'h3002);
        end_sim();
    end
endmodule
